/* File: hdl/asfr_decim.sv */
`timescale 1ns/1ps
`default_nettype none
module asfr_decim (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_b_in,
    input  wire logic                          base_tick_in,
    input  wire logic [asfr_pkg::DIV_W-1:0]    div_log2_in,
    output logic                               tick_out
);
    logic [asfr_pkg::DECIM_W-1:0] count;
    logic [asfr_pkg::DECIM_W-1:0] mask;

    // one shared base stream; slower rates keep every 2^n-th tick
    assign mask = (16'h0001 << div_log2_in) - 16'h0001;
    assign tick_out = base_tick_in && ((count & mask) == mask); // RL17

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            count <= 16'h0000;
        end else if (base_tick_in) begin
            count <= count + 16'h0001;
        end
    end

    property p_decim_on_base;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        tick_out |-> base_tick_in && (count[0] || div_log2_in == 4'h0);
    endproperty
    a_decim_on_base: assert property (p_decim_on_base) // RL17
        else $error("decimated tick without base tick");
endmodule : asfr_decim
`default_nettype wire

/* File: hdl/asfr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module asfr_fifo (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_b_in,
    input  wire logic                          flush_in,
    input  wire logic                          push_in,
    input  wire logic                          pop_in,
    input  wire logic [asfr_pkg::SAMPLE_W-1:0] data_in,
    output logic [asfr_pkg::SAMPLE_W-1:0]      front_out,
    output logic [asfr_pkg::CNT_W-1:0]         count_out
);
    logic [asfr_pkg::SAMPLE_W-1:0] mem [asfr_pkg::DEPTH];
    logic [4:0]                    wr_ptr;
    logic [4:0]                    rd_ptr;

    assign front_out = mem[rd_ptr];

    always_ff @(posedge clk_sys_in) begin
        if (push_in && !flush_in) begin
            mem[wr_ptr] <= data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in || flush_in) begin
            wr_ptr    <= 5'h00;
            rd_ptr    <= 5'h00;
            count_out <= 6'h00;
        end else begin
            if (push_in) begin
                wr_ptr <= wr_ptr + 5'h01;
            end
            if (pop_in) begin
                rd_ptr <= rd_ptr + 5'h01;
            end
            count_out <= count_out + {5'h00, push_in} - {5'h00, pop_in};
        end
    end

    property p_depth_limit;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        count_out <= asfr_pkg::DEPTH_CNT;
    endproperty
    a_depth_limit: assert property (p_depth_limit) // RL16
        else $error("queue holds more than its depth");
endmodule : asfr_fifo
`default_nettype wire

/* File: hdl/asfr_pkg.sv */
package asfr_pkg;
    localparam logic [7:0] ADDR_X_LO  = 8'h32;
    localparam logic [7:0] ADDR_X_HI  = 8'h33;
    localparam logic [7:0] ADDR_Y_LO  = 8'h34;
    localparam logic [7:0] ADDR_Y_HI  = 8'h35;
    localparam logic [7:0] ADDR_Z_LO  = 8'h36;
    localparam logic [7:0] ADDR_Z_HI  = 8'h37;
    localparam logic [7:0] ADDR_CTRL  = 8'h38;
    localparam logic [7:0] ADDR_STAT  = 8'h39;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int MODE_MSB  = 7;
    localparam int MODE_LSB  = 6;
    localparam int TRIG_BIT  = 5;
    localparam int SAMP_MSB  = 4;
    localparam int STAT_TRIG = 7;
    localparam int DEPTH     = 32;
    localparam int CNT_W     = 6;
    localparam int AXIS_W    = 16;
    localparam int SAMPLE_W  = 48;
    localparam int DIV_W     = 4;
    localparam int DECIM_W   = 16;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 6'h20;
    localparam logic [DIV_W-1:0] SLEEP_DIV_BASE = 4'h7;
    typedef enum logic [1:0] {
        MODE_BYPASS,
        MODE_COLLECT,
        MODE_STREAM,
        MODE_TRIGGER
    } asfr_mode_type;
    typedef enum logic {
        ST_AWAKE,
        ST_ASLEEP
    } asfr_sleep_type;
endpackage : asfr_pkg

/* File: hdl/asfr_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RL1) six read-only bytes hold x, y, z results at consecutive addresses
// (RL2) results are twos complement, low byte at lower address
// (RL3) host should read all six bytes in one burst
// (RL4) mode field top bits: bypass, collect, stream, triggered capture
// (RL5) collect mode stores up to 32, stops when full, resumes on space
// (RL6) stream mode keeps latest 32, oldest dropped when full
// (RL7) trigger mode keeps pre-trigger samples, then collects until full
// (RL8) trigger-source bit picks irq pin a (0) or irq pin b (1)
// (RL9) sample count zero sets watermark at once in every mode
// (RL10) collect and stream: sample count is the watermark level
// (RL11) trigger mode: sample count is pre-trigger samples retained
// (RL12) host should not use count zero in trigger mode
// (RL13) status top bit shows a trigger event has occurred
// (RL14) status low field is entry count, bit six reads zero
// (RL15) data register read pops one entry; host reads a sample in a burst
// (RL16) queue holds 32 plus one sample at the output stage
// (RL17) lower rates decimate one stream; activity sees undecimated samples
// (RL18) linked mode alternates detection; uncleared activity blocks sleep
// (RL19) linked autosleep: inactivity sleeps, swaps to activity detection
// (RL20) activity while asleep wakes, flags activity, swaps detection back
// (RL21) low-power setting preferred over sleep for low-rate capture
// (RL22) sleep suppresses new-sample flag and queue writes, uses wake rate
// (RL23) new-sample, watermark, overrun flags set always, cleared by data read; watermark here tracks entry count, only in collect/stream or count zero
// (RL24) watermark holds while entries reach the sample count
module asfr_top (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic        base_tick_in,
    input  wire logic [15:0] sample_x_in,
    input  wire logic [15:0] sample_y_in,
    input  wire logic [15:0] sample_z_in,
    input  wire logic [3:0]  rate_div_in,
    input  wire logic [1:0]  wakeup_rate_in,
    input  wire logic        link_en_in,
    input  wire logic        auto_sleep_in,
    input  wire logic        sleep_bit_in,
    input  wire logic        act_det_in,
    input  wire logic        inact_det_in,
    input  wire logic        irq_pin_a_in,
    input  wire logic        irq_pin_b_in,
    input  wire logic        src_read_in,
    input  wire logic        frame_sel_b_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output logic             data_ready_out,
    output logic             watermark_out,
    output logic             overrun_out,
    output logic             activity_flag_out,
    output logic             inactivity_flag_out,
    output logic             sleeping_out,
    output logic             act_det_en_out,
    output logic             inact_det_en_out
);
    logic [7:0]                    ctrl;
    asfr_pkg::asfr_mode_type       mode;
    asfr_pkg::asfr_mode_type       next_mode;
    logic                          trig_src;
    logic [4:0]                    samples;
    logic                          ctrl_wr;
    logic                          flush;
    logic                          fs_meta;
    logic                          fs_sync;
    logic                          fs_prev;
    logic                          frame_end;
    logic                          data_rd_pending;
    logic                          pop_pulse;
    logic [3:0]                    div_sel;
    logic                          s_tick;
    logic                          take_sample;
    logic [asfr_pkg::SAMPLE_W-1:0] sample_vec;
    logic [asfr_pkg::SAMPLE_W-1:0] head;
    logic                          head_valid;
    logic                          head_free;
    logic [asfr_pkg::SAMPLE_W-1:0] fifo_front;
    logic [asfr_pkg::CNT_W-1:0]    fifo_count;
    logic [asfr_pkg::CNT_W-1:0]    eff_count;
    logic                          host_pop_fifo;
    logic                          fifo_push;
    logic                          fifo_pop;
    logic                          drop;
    logic                          to_head;
    logic                          overrun_ev;
    logic                          collecting;
    logic                          event_seen;
    logic                          trig_prev;
    logic                          trig_level;
    logic                          trig_ev;
    logic                          next_wm;
    logic                          look_act;
    asfr_pkg::asfr_sleep_type      state;
    logic                          sleeping;

    assign mode = asfr_pkg::asfr_mode_type'(
        ctrl[asfr_pkg::MODE_MSB:asfr_pkg::MODE_LSB]); // RL4
    assign next_mode = asfr_pkg::asfr_mode_type'(
        reg_wdata_in[asfr_pkg::MODE_MSB:asfr_pkg::MODE_LSB]);
    assign trig_src = ctrl[asfr_pkg::TRIG_BIT];
    assign samples  = ctrl[asfr_pkg::SAMP_MSB:0];
    assign ctrl_wr  = reg_wr_in && (reg_addr_in == asfr_pkg::ADDR_CTRL);
    // a mode change empties the queue, but the output stage keeps its sample from the old mode
    assign flush    = ctrl_wr && (next_mode != mode);

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ctrl <= asfr_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= reg_wdata_in;
        end
    end

    // frame select pin crosses in through two flops
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fs_meta <= 1'b1;
            fs_sync <= 1'b1;
            fs_prev <= 1'b1;
        end else begin
            fs_meta <= frame_sel_b_in;
            fs_sync <= fs_meta;
            fs_prev <= fs_sync;
        end
    end
    assign frame_end = fs_sync && !fs_prev;

    // pop once per frame, so outside bypass a six-byte burst on ready data sees one sample
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            data_rd_pending <= 1'b0;
        end else if (frame_end) begin
            data_rd_pending <= 1'b0;
        end else if (reg_rd_in && reg_addr_in >= asfr_pkg::ADDR_X_LO
                     && reg_addr_in <= asfr_pkg::ADDR_Z_HI) begin
            data_rd_pending <= 1'b1; // RL15
        end
    end
    assign pop_pulse = frame_end && data_rd_pending; // RL15

    assign sleeping = (state == asfr_pkg::ST_ASLEEP) || sleep_bit_in;
    assign div_sel  = sleeping
        ? asfr_pkg::SLEEP_DIV_BASE + {2'b00, wakeup_rate_in} // RL22
        : rate_div_in;

    asfr_decim u_decim (
        .clk_sys_in   (clk_sys_in),
        .rst_b_in     (rst_b_in),
        .base_tick_in (base_tick_in),
        .div_log2_in  (div_sel),
        .tick_out     (s_tick)
    );

    assign sample_vec  = {sample_z_in, sample_y_in, sample_x_in};
    assign take_sample = s_tick && !sleeping && !flush; // RL22
    assign host_pop_fifo = pop_pulse && (mode != asfr_pkg::MODE_BYPASS)
                           && (fifo_count != 6'h00);
    assign head_free = !head_valid || (pop_pulse && !host_pop_fifo);
    assign eff_count = fifo_count - {5'h00, host_pop_fifo};
    assign collecting = (mode == asfr_pkg::MODE_COLLECT)
        || ((mode == asfr_pkg::MODE_TRIGGER) && event_seen);

    always_comb begin
        to_head    = 1'b0;
        fifo_push  = 1'b0;
        drop       = 1'b0;
        overrun_ev = 1'b0;
        if (take_sample) begin
            if (mode == asfr_pkg::MODE_BYPASS || head_free) begin
                to_head = 1'b1; // RL16
            end else if (collecting) begin
                if (eff_count < asfr_pkg::DEPTH_CNT) begin
                    fifo_push = 1'b1; // RL5 RL7
                end else begin
                    overrun_ev = 1'b1;
                end
            end else if (mode == asfr_pkg::MODE_STREAM) begin
                fifo_push = 1'b1;
                if (eff_count == asfr_pkg::DEPTH_CNT) begin
                    drop       = 1'b1; // RL6
                    overrun_ev = 1'b1;
                end
            end else begin
                fifo_push = 1'b1;
                if (eff_count >= {1'b0, samples} && eff_count != 6'h00
                    && !host_pop_fifo) begin
                    drop = 1'b1; // RL11
                end
            end
        end
    end
    assign fifo_pop = host_pop_fifo || drop;

    asfr_fifo u_fifo (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .flush_in   (flush),
        .push_in    (fifo_push),
        .pop_in     (fifo_pop),
        .data_in    (sample_vec),
        .front_out  (fifo_front),
        .count_out  (fifo_count)
    );

    // output stage is the extra entry beyond the queue depth
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            head       <= 48'h0000_0000_0000;
            head_valid <= 1'b0;
        end else begin
            if (host_pop_fifo) begin
                head <= fifo_front; // RL15
            end else if (pop_pulse) begin
                head_valid <= 1'b0; // RL23
            end
            if (to_head) begin
                head       <= sample_vec;
                head_valid <= 1'b1;
            end
        end
    end

    assign trig_level = trig_src ? irq_pin_b_in : irq_pin_a_in; // RL8
    assign trig_ev    = trig_level && !trig_prev;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            trig_prev  <= 1'b0;
            event_seen <= 1'b0;
        end else begin
            trig_prev <= trig_level;
            if (mode == asfr_pkg::MODE_TRIGGER && trig_ev) begin
                event_seen <= 1'b1; // RL13
            end else if (ctrl_wr) begin
                event_seen <= 1'b0;
            end
        end
    end

    assign next_wm = (samples == 5'h00) // RL9
        || ((mode == asfr_pkg::MODE_COLLECT
             || mode == asfr_pkg::MODE_STREAM)
            && fifo_count >= {1'b0, samples}); // RL10 RL24

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            watermark_out <= 1'b0;
            overrun_out   <= 1'b0;
        end else begin
            watermark_out <= next_wm;
            if (overrun_ev) begin
                overrun_out <= 1'b1; // RL23
            end else if (pop_pulse) begin
                overrun_out <= 1'b0;
            end
        end
    end
    assign data_ready_out = head_valid; // RL23

    // linked mode: look for inactivity first, then only for activity, then back to inactivity once activity is seen
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            look_act <= 1'b0;
        end else if (!link_en_in) begin
            look_act <= 1'b0;
        end else if (!look_act && inact_det_in) begin
            look_act <= 1'b1; // RL18 RL19
        end else if (look_act && act_det_in) begin
            look_act <= 1'b0; // RL20
        end
    end
    assign act_det_en_out   = !link_en_in || look_act;
    assign inact_det_en_out = !link_en_in || !look_act;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state <= asfr_pkg::ST_AWAKE;
        end else begin
            unique case (state)
                asfr_pkg::ST_AWAKE: begin
                    if (link_en_in && auto_sleep_in && !look_act
                        && inact_det_in && !activity_flag_out) begin
                        state <= asfr_pkg::ST_ASLEEP; // RL18 RL19
                    end
                end
                asfr_pkg::ST_ASLEEP: begin
                    if (act_det_in || !link_en_in || !auto_sleep_in) begin
                        state <= asfr_pkg::ST_AWAKE; // RL20
                    end
                end
            endcase
        end
    end
    assign sleeping_out = sleeping;

    // set wins over a source-register read in the same cycle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            activity_flag_out   <= 1'b0;
            inactivity_flag_out <= 1'b0;
        end else begin
            if (act_det_in && act_det_en_out) begin
                activity_flag_out <= 1'b1; // RL20
            end else if (src_read_in) begin
                activity_flag_out <= 1'b0; // RL18
            end
            if (inact_det_in && inact_det_en_out) begin
                inactivity_flag_out <= 1'b1;
            end else if (src_read_in) begin
                inactivity_flag_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                asfr_pkg::ADDR_X_LO: reg_rdata_out <= head[7:0]; // RL1 RL2
                asfr_pkg::ADDR_X_HI: reg_rdata_out <= head[15:8];
                asfr_pkg::ADDR_Y_LO: reg_rdata_out <= head[23:16];
                asfr_pkg::ADDR_Y_HI: reg_rdata_out <= head[31:24];
                asfr_pkg::ADDR_Z_LO: reg_rdata_out <= head[39:32];
                asfr_pkg::ADDR_Z_HI: reg_rdata_out <= head[47:40];
                asfr_pkg::ADDR_CTRL: reg_rdata_out <= ctrl;
                asfr_pkg::ADDR_STAT:
                    reg_rdata_out <= {event_seen, 1'b0, fifo_count}; // RL14
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    property p_bypass_empty;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        mode == asfr_pkg::MODE_BYPASS |-> fifo_count == 6'h00;
    endproperty
    a_bypass_empty: assert property (p_bypass_empty) // RL4
        else $error("queue not empty in bypass");

    property p_collect_full;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        mode == asfr_pkg::MODE_COLLECT && fifo_count == 6'h20
        && take_sample && head_valid && !pop_pulse && !ctrl_wr
        |=> fifo_count == 6'h20 && overrun_out;
    endproperty
    a_collect_full: assert property (p_collect_full) // RL5
        else $error("collect mode did not stop when full");

    property p_stream_full;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        mode == asfr_pkg::MODE_STREAM && fifo_count == 6'h20
        && take_sample && head_valid && !pop_pulse && !ctrl_wr
        |=> fifo_count == 6'h20 && overrun_out;
    endproperty
    a_stream_full: assert property (p_stream_full) // RL6
        else $error("stream mode did not drop oldest");

    property p_zero_wm;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        samples == 5'h00 |=> watermark_out;
    endproperty
    a_zero_wm: assert property (p_zero_wm) // RL9
        else $error("zero sample count did not set watermark");

    property p_trig_seen;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        mode == asfr_pkg::MODE_TRIGGER && trig_ev
        |=> event_seen ##1 (event_seen || $past(ctrl_wr));
    endproperty
    a_trig_seen: assert property (p_trig_seen) // RL13
        else $error("trigger event not recorded");

    property p_auto_sleep;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state == asfr_pkg::ST_AWAKE && link_en_in && auto_sleep_in
        && !look_act && inact_det_in && !activity_flag_out
        |=> sleeping_out && act_det_en_out && !inact_det_en_out;
    endproperty
    a_auto_sleep: assert property (p_auto_sleep) // RL19
        else $error("inactivity did not enter sleep");

    property p_wake;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state == asfr_pkg::ST_ASLEEP && act_det_in && act_det_en_out
        |=> state == asfr_pkg::ST_AWAKE && activity_flag_out
            && inact_det_en_out;
    endproperty
    a_wake: assert property (p_wake) // RL20
        else $error("activity did not wake the device");

    property p_sleep_no_write;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        sleeping |-> !fifo_push && !to_head;
    endproperty
    a_sleep_no_write: assert property (p_sleep_no_write) // RL22
        else $error("sample stored while asleep");

    property p_overrun_clear;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        pop_pulse && !overrun_ev |=> !overrun_out;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) // RL23
        else $error("overrun not cleared by data read");
endmodule : asfr_top
`default_nettype wire

/* File: verif/asfr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asfr_host_model (
    input  wire logic       clk_in,
    output logic            rd_out,
    output logic            wr_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            frame_sel_b_out,
    output logic            src_read_out
);
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
        frame_sel_b_out = 1'b1;
        src_read_out = 1'b0;
    end
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        // idle address lines toggle so a stale value never looks valid
        addr_out = ~a;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : wr
    // whole sample in one frame, since data reads pop one entry when the frame ends
    task automatic burst;
        @(posedge clk_in);
        #1;
        frame_sel_b_out = 1'b0;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 6; i++) rd(8'h32 + 8'(i));
        frame_sel_b_out = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
    endtask : burst
    task automatic src_clear;
        @(posedge clk_in);
        #1;
        src_read_out = 1'b1;
        @(posedge clk_in);
        #1;
        src_read_out = 1'b0;
    endtask : src_clear
endmodule : asfr_host_model
`default_nettype wire

/* File: verif/asfr_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module asfr_top_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        tick = 1'b0;
    logic [15:0] sx = 16'h0000;
    logic [15:0] sy = 16'h0000;
    logic [15:0] sz = 16'h0000;
    logic        slp = 1'b0;
    logic        inact = 1'b0;
    logic        lnk = 1'b0, aslp = 1'b0, act = 1'b0;
    logic [3:0]  rdiv = 4'h0;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    logic        rd, wr, fsb, src, rd_pend = 1'b0;
    logic [7:0]  addr, wdata, rdata;
    logic        dr, wm, ovr, actf, inactf, slpo, aen, ien;
    int          errors = 0;
    int          comparisons = 0;
    int          seed = 84;
    int          cycles = 0;
    logic [47:0] hist[$];
    logic [7:0]  expq[$];
    always #5 clk_sys_in = ~clk_sys_in;
    asfr_host_model asfr_host_model_inst (.clk_in(clk_sys_in), .rd_out(rd),
        .wr_out(wr), .addr_out(addr), .wdata_out(wdata),
        .frame_sel_b_out(fsb), .src_read_out(src));
    asfr_top asfr_top_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .base_tick_in(tick), .sample_x_in(sx), .sample_y_in(sy),
        .sample_z_in(sz), .rate_div_in(rdiv), .wakeup_rate_in(2'h0),
        .link_en_in(lnk), .auto_sleep_in(aslp), .sleep_bit_in(slp),
        .act_det_in(act), .inact_det_in(inact), .irq_pin_a_in(pin_a),
        .irq_pin_b_in(pin_b), .src_read_in(src), .frame_sel_b_in(fsb),
        .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .data_ready_out(dr),
        .watermark_out(wm), .overrun_out(ovr), .activity_flag_out(actf),
        .inactivity_flag_out(inactf), .sleeping_out(slpo),
        .act_det_en_out(aen), .inact_det_en_out(ien));
    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp8
    task automatic chk(string n, logic e, logic g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk
    // read data is compared against the oldest note one edge after the read
    always @(posedge clk_sys_in) begin
        rd_pend <= rd;
        if (rd_pend) begin
            #1;
            if (expq.size() == 0) cmp8("reg_rdata_out", 8'hxx, rdata);
            else cmp8("reg_rdata_out", expq.pop_front(), rdata);
        end
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic rdx(logic [7:0] a, logic [7:0] e);
        expq.push_back(e);
        asfr_host_model_inst.rd(a);
    endtask : rdx
    task automatic wrc(logic [7:0] d);
        asfr_host_model_inst.wr(8'h38, d);
        repeat (2) @(posedge clk_sys_in);
    endtask : wrc
    task automatic ticks(int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            #1;
            tick = 1'b1;
            sx = 16'($random(seed));
            sy = 16'($random(seed));
            sz = 16'($random(seed));
            hist.push_back({sz, sy, sx});
            @(posedge clk_sys_in);
            #1;
            tick = 1'b0;
        end
        repeat (3) @(posedge clk_sys_in);
    endtask : ticks
    task automatic sample(int i);
        for (int k = 0; k < 6; k++) expq.push_back(8'(hist[i] >> (8 * k)));
        asfr_host_model_inst.burst();
    endtask : sample
    task automatic pin(logic b);
        @(posedge clk_sys_in);
        #1;
        if (b) pin_b = 1'b1;
        else pin_a = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        pin_a = 1'b0;
        pin_b = 1'b0;
        repeat (5) @(posedge clk_sys_in);
    endtask : pin
    task automatic det(logic a);
        @(posedge clk_sys_in);
        #1;
        if (a) act = 1'b1;
        else inact = 1'b1;
        @(posedge clk_sys_in);
        #1;
        act = 1'b0;
        inact = 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask : det
    initial begin
        repeat (5) @(posedge clk_sys_in);
        #1;
        rst_b_in = 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk("watermark_out", 1'b1, wm);
        rdx(8'h39, 8'h00);
        rdx(8'h38, 8'h00);
        rdx(8'h10, 8'h00);
        asfr_host_model_inst.wr(8'h39, 8'hff);
        rdx(8'h39, 8'h00);
        wrc(8'h45);
        rdx(8'h38, 8'h45);
        chk("watermark_out", 1'b0, wm);
        ticks(4);
        chk("watermark_out", 1'b0, wm);
        ticks(3);
        chk("watermark_out", 1'b1, wm);
        ticks(40);
        rdx(8'h39, 8'h20);
        chk("data_ready_out", 1'b1, dr);
        chk("overrun_out", 1'b1, ovr);
        sample(0);
        rdx(8'h39, 8'h1f);
        chk("overrun_out", 1'b0, ovr);
        ticks(1);
        rdx(8'h39, 8'h20);
        wrc(8'h84);
        ticks(40);
        rdx(8'h39, 8'h20);
        sample(1);
        sample(56);
        slp = 1'b1;
        ticks(5);
        rdx(8'h39, 8'h1e);
        slp = 1'b0;
        wrc(8'he3);
        ticks(10);
        rdx(8'h39, 8'h03);
        pin(1'b0);
        rdx(8'h39, 8'h03);
        pin(1'b1);
        rdx(8'h39, 8'h83);
        ticks(40);
        rdx(8'h39, 8'ha0);
        wrc(8'h40);
        chk("watermark_out", 1'b1, wm);
        rdx(8'h39, 8'h00);
        rdiv = 4'h1;
        ticks(4);
        rdx(8'h39, 8'h02);
        det(1'b0);
        chk("inactivity_flag_out", 1'b1, inactf);
        asfr_host_model_inst.src_clear();
        repeat (2) @(posedge clk_sys_in);
        chk("inactivity_flag_out", 1'b0, inactf);
        #1;
        lnk = 1'b1;
        aslp = 1'b1;
        det(1'b0);
        chk("sleeping_out", 1'b1, slpo);
        chk("act_det_en_out", 1'b1, aen);
        chk("inact_det_en_out", 1'b0, ien);
        det(1'b1);
        chk("sleeping_out", 1'b0, slpo);
        chk("activity_flag_out", 1'b1, actf);
        det(1'b0);
        chk("sleeping_out", 1'b0, slpo);
        asfr_host_model_inst.src_clear();
        chk("activity_flag_out", 1'b0, actf);
        repeat (5) @(posedge clk_sys_in);
        report_and_stop();
    end
endmodule : asfr_top_tb_top
`default_nettype wire
